// ===== pkg/pewp_defs.svh
`ifndef PEWP_DEFS_SVH
`define PEWP_DEFS_SVH
// Behaviour
// - Host gates off write strobes while supply is low.
// - Host polls until bit 7 matches the written byte, or the programming time runs out, before finishing.
// - Address is captured when the request is taken and held for the whole cycle.
// - Direction is low for reads and high for writes, but the first setup cycle keeps the previous request's direction.
// - Bus is released for the memory during a read, except the first setup cycle of a read that follows a write.
// - Output enable follows the data strobe on a read.
// - Fixed phase counts end each transfer; read data taken at the end of the strobe.

// Write programming time bound, in microseconds
`define PEWP_PROG_TIME_US   5000
`define PEWP_CLK_MHZ        125
// Longest programming time in cycles; polling gives up beyond it
`define PEWP_PROG_CYCLES    (`PEWP_PROG_TIME_US * `PEWP_CLK_MHZ)
// Strobe phase lengths in cycles (address setup, strobe width, recovery)
`define PEWP_SETUP_CYC      2
`define PEWP_STROBE_CYC     4
`define PEWP_RECOV_CYC      2
`define PEWP_POLL_BIT       7
`endif

// ===== pkg/pewp_pkg.sv
package pewp_pkg;
  // Cycle sequencer states
  typedef enum logic [6:0] {
    PEWP_IDLE   = 7'b000_0001,
    PEWP_SETUP  = 7'b000_0010,
    PEWP_STROBE = 7'b000_0100,
    PEWP_RECOV  = 7'b000_1000,
    PEWP_PSETUP = 7'b001_0000,
    PEWP_PSTRB  = 7'b010_0000,
    PEWP_PRECOV = 7'b100_0000
  } pewp_state_t;
endpackage : pewp_pkg

// ===== src/pewp_sync.sv
// Two-stage synchroniser for a group of pin inputs
module pewp_sync #(
  parameter int W = 8
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_reg;

  // First stage feeds only the second
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= '0;
      sync_o   <= '0;
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end
endmodule : pewp_sync

// ===== src/pewp_host.sv
`include "pewp_defs.svh"
// Host controller: turns one-cycle read/write requests into EEPROM pin cycles
module pewp_host #(
  parameter int AW         = 12,
  parameter int PROG_CYCLES = `PEWP_PROG_CYCLES
) (
  // Clock and reset
  input  wire logic          core_clk_i,
  input  wire logic          rst_n_i,
  // User requests
  input  wire logic          req_i,
  input  wire logic          req_write_i,
  input  wire logic [AW-1:0] req_addr_i,
  input  wire logic [7:0]    req_wdata_i,
  input  wire logic          supply_ok_i,
  output logic               busy_o,
  output logic               done_o,
  output logic               timeout_o,
  output logic [7:0]         rdata_o,
  // Device pins
  output logic [AW-1:0]      ee_addr_o,
  output logic               ee_ce_n_o,
  output logic               ee_oe_n_o,
  output logic               ee_we_n_o,
  output logic [7:0]         ee_data_o,
  output logic               ee_data_oe_o,
  input  wire logic [7:0]    ee_data_i
);
  localparam logic [3:0]  SETUP_C  = 4'(`PEWP_SETUP_CYC);
  localparam logic [3:0]  STROBE_C = 4'(`PEWP_STROBE_CYC);
  localparam logic [3:0]  RECOV_C  = 4'(`PEWP_RECOV_CYC);
  localparam logic [31:0] PROG_C   = 32'(PROG_CYCLES);

  pewp_pkg::pewp_state_t state_reg;
  pewp_pkg::pewp_state_t state_next;
  logic [3:0]  phase_reg;
  logic [31:0] prog_reg;
  logic        wr_reg;
  logic [7:0]  wdata_reg;
  logic [7:0]  pin_data;
  logic        supply_sync;
  // Check helper only: cycles spent in the current request
  logic [31:0] busy_cnt_reg;

  // Data pins and supply status come from outside the clock domain
  pewp_sync #(.W(9)) u_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .async_i    ({supply_ok_i, ee_data_i}),
    .sync_o     ({supply_sync, pin_data})
  );

  function automatic logic phase_end(input logic [3:0] cnt, input logic [3:0] lim);
    return cnt == lim - 4'h1;
  endfunction : phase_end

  // Phase end decode
  wire setup_end  = phase_end(phase_reg, SETUP_C);
  wire strobe_end = phase_end(phase_reg, STROBE_C);
  wire recov_end  = phase_end(phase_reg, RECOV_C);
  // Sample late in the strobe so the slowest access has settled
  wire poll_match = pin_data[`PEWP_POLL_BIT] == wdata_reg[`PEWP_POLL_BIT];
  wire prog_over  = prog_reg >= PROG_C;
  wire start      = req_i && (state_reg == pewp_pkg::PEWP_IDLE);

  // Next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      pewp_pkg::PEWP_IDLE:   if (start) state_next = pewp_pkg::PEWP_SETUP;
      pewp_pkg::PEWP_SETUP:  if (setup_end) state_next = pewp_pkg::PEWP_STROBE;
      pewp_pkg::PEWP_STROBE: if (strobe_end) state_next = pewp_pkg::PEWP_RECOV;
      pewp_pkg::PEWP_RECOV: begin
        if (recov_end) state_next = wr_reg ? pewp_pkg::PEWP_PSETUP : pewp_pkg::PEWP_IDLE;
      end
      // Polling reads repeat the ordinary read sequence
      pewp_pkg::PEWP_PSETUP: if (setup_end) state_next = pewp_pkg::PEWP_PSTRB;
      pewp_pkg::PEWP_PSTRB:  if (strobe_end) state_next = pewp_pkg::PEWP_PRECOV;
      pewp_pkg::PEWP_PRECOV: begin
        if (recov_end) begin
          state_next = (poll_match || prog_over) ? pewp_pkg::PEWP_IDLE
                                                 : pewp_pkg::PEWP_PSETUP;
        end
      end
      default: state_next = pewp_pkg::PEWP_IDLE;
    endcase
  end

  wire phase_change = state_next != state_reg;
  wire in_strobe    = state_next == pewp_pkg::PEWP_STROBE ||
                      state_next == pewp_pkg::PEWP_PSTRB;
  wire in_cycle     = state_next != pewp_pkg::PEWP_IDLE;
  // Write strobe only while supply is good; gating has no status bit of its own
  wire we_next      = !(in_strobe && state_next == pewp_pkg::PEWP_STROBE && wr_reg
                        && supply_sync);
  // Output enable only on reads, and never together with write enable
  wire oe_next      = !(in_strobe && !(state_next == pewp_pkg::PEWP_STROBE && wr_reg));
  wire finish       = (state_reg == pewp_pkg::PEWP_RECOV && recov_end && !wr_reg) ||
                      (state_reg == pewp_pkg::PEWP_PRECOV && recov_end &&
                       (poll_match || prog_over));

  // Sequencer and counters
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= pewp_pkg::PEWP_IDLE;
      phase_reg <= 4'h0;
      prog_reg  <= 32'h0;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_change ? 4'h0 : phase_reg + 4'h1;
      if (start) prog_reg <= 32'h0;
      else if (!prog_over) prog_reg <= prog_reg + 32'h1;
    end
  end

  // Request capture: address held stable for the whole cycle
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_reg    <= 1'b0;
      wdata_reg <= 8'h00;
      ee_addr_o <= '0;
    end else if (start) begin
      wr_reg    <= req_write_i;
      wdata_reg <= req_wdata_i;
      ee_addr_o <= req_addr_i;
    end
  end

  // Pin drivers, all registered
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ee_ce_n_o    <= 1'b1;
      ee_oe_n_o    <= 1'b1;
      ee_we_n_o    <= 1'b1;
      ee_data_o    <= 8'h00;
      ee_data_oe_o <= 1'b0;
    end else begin
      ee_ce_n_o    <= !in_strobe;
      ee_oe_n_o    <= oe_next;
      ee_we_n_o    <= we_next;
      ee_data_o    <= wdata_reg;
      // Drive data in the write phase, released on reads; the first setup cycle still follows the previous request
      ee_data_oe_o <= in_cycle && wr_reg && state_next != pewp_pkg::PEWP_PSETUP &&
                      state_next != pewp_pkg::PEWP_PSTRB &&
                      state_next != pewp_pkg::PEWP_PRECOV;
    end
  end

  // Status outputs
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_o    <= 1'b0;
      done_o    <= 1'b0;
      timeout_o <= 1'b0;
      rdata_o   <= 8'h00;
    end else begin
      busy_o    <= in_cycle;
      done_o    <= finish;
      if (start) timeout_o <= 1'b0;
      else if (finish && wr_reg && !poll_match) timeout_o <= 1'b1;
      if (state_reg == pewp_pkg::PEWP_STROBE && strobe_end && !wr_reg) begin
        rdata_o <= pin_data;
      end
    end
  end

  // Check helper: counts busy cycles so the polling bound can be asserted
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_cnt_reg <= 32'h0;
    end else if (!busy_o) begin
      busy_cnt_reg <= 32'h0;
    end else if (busy_cnt_reg != 32'hffff_ffff) begin
      busy_cnt_reg <= busy_cnt_reg + 32'h1; // Saturates so a hang cannot wrap past the check
    end
  end

  // Strobe legality: never read and write at once, never enable without select
  chk_strobe_excl: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !(!ee_oe_n_o && !ee_we_n_o)) else $error("oe and we both low");
  chk_ce_oe: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !ee_oe_n_o |-> !ee_ce_n_o) else $error("oe without ce");
  chk_write_combo: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !ee_we_n_o |-> !ee_ce_n_o && ee_oe_n_o && ee_data_oe_o)
    else $error("write strobe without select or data drive");
  chk_data_steady: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !ee_we_n_o |-> $stable(ee_data_o)) else $error("write data moved under strobe");
  chk_we_width: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $fell(ee_we_n_o) |-> !ee_we_n_o [*4] ##1 ee_we_n_o)
    else $error("bad write strobe width");

  // Supply gating: a strobe only starts with the supply seen good
  chk_we_supply: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $fell(ee_we_n_o) |-> $past(supply_sync)) else $error("write with low supply");

  // Bus ownership and address hold across the whole cycle
  chk_read_release: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !ee_oe_n_o |-> !ee_data_oe_o) else $error("bus driven during read");
  chk_addr_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    busy_o && $past(busy_o) && !$past(start) |-> $stable(ee_addr_o))
    else $error("address moved mid cycle");

  // Completion: one-cycle done, idle with it, polling bounded by the timer
  chk_done_pulse: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    done_o |=> !done_o) else $error("done longer than one cycle");
  chk_done_idle: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    done_o |-> !busy_o) else $error("done while still busy");
  chk_poll_done: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    done_o && $past(wr_reg) && !timeout_o |->
    $past(pin_data[`PEWP_POLL_BIT]) == wdata_reg[`PEWP_POLL_BIT]) else $error("done without match");
  chk_poll_bound: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (busy_cnt_reg <= PROG_C + 32'h10)) else $error("polling ran past the programming bound");

  // Coverage of the main scenarios
  cov_write: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $fell(ee_we_n_o));
  cov_poll: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state_reg == pewp_pkg::PEWP_PSTRB);
  cov_read_done: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    done_o && !wr_reg);
  cov_timeout: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(timeout_o));
  cov_gated: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !ee_ce_n_o && ee_oe_n_o && ee_we_n_o);
endmodule : pewp_host

// ===== sim/pewp_eeprom_model.sv
// Behavioural byte-wide nonvolatile memory seen from its pins
module pewp_eeprom_model #(
  parameter int  AW     = 12,
  parameter time PROG_T = 400ns
) (
  // Device pins
  input  wire logic [AW-1:0] addr_i,
  input  wire logic          ce_n_i,
  input  wire logic          oe_n_i,
  input  wire logic          we_n_i,
  input  wire logic [7:0]    data_i,
  input  wire logic          vcc_ok_i,
  output logic      [7:0]    data_o,
  output logic               prog_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]    mem [2**AW];
  logic [AW-1:0] wa;
  logic [7:0]    last;
  logic [7:0]    held;
  logic          arm;
  // Mode decode
  wire rd = !ce_n_i && !oe_n_i && we_n_i;
  wire wr = !ce_n_i && oe_n_i && !we_n_i;
  // Polling shows the inverted top bit whatever the address
  wire [7:0] drv = prog_o ? {~last[7], 7'h2a} : mem[addr_i];
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    prog_o = 1'b0;
    arm = 1'b0;
    last = 8'h00;
    held = 8'h00;
  end
  // Address on the later falling edge; only a fresh edge arms a write
  always @(negedge ce_n_i or negedge we_n_i) begin
    if (wr && vcc_ok_i && !prog_o) begin
      wa = addr_i;
      arm = 1'b1;
    end
  end
  // Supply loss kills a pending write
  always @(negedge vcc_ok_i) arm = 1'b0;
  // Data on the earlier rising edge, then self-timed programming
  always @(posedge ce_n_i or posedge we_n_i) begin
    if (arm) begin
      arm = 1'b0;
      last = data_i;
      mem[wa] = data_i;
      prog_o = 1'b1;
      prog_o <= #PROG_T 1'b0;
    end
  end
  // Released pins show the inverse so a stale value never passes
  always @(drv or rd) if (rd) held = drv;
  assign data_o = rd ? drv : ~held;
endmodule : pewp_eeprom_model

// ===== sim/parallel_eeprom_write_and_polling_tb.sv
module parallel_eeprom_write_and_polling_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int AW = 12;
  logic          core_clk, rst_n, req, req_write, supply_ok;
  logic [AW-1:0] req_addr, ee_addr;
  logic [7:0]    req_wdata, rdata, ee_data, dev_q;
  logic          busy, done, timeout, ce_n, oe_n, we_n, data_oe, prog;
  int            n_fail, n_compared, wait_n, n_we;
  // Shared data wire: host drives while enabled, else the device
  wire [7:0] ee_bus = data_oe ? ee_data : dev_q;
  pewp_host #(.AW(AW), .PROG_CYCLES(200)) dut (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .req_i(req), .req_write_i(req_write),
    .req_addr_i(req_addr), .req_wdata_i(req_wdata), .supply_ok_i(supply_ok),
    .busy_o(busy), .done_o(done), .timeout_o(timeout), .rdata_o(rdata),
    .ee_addr_o(ee_addr), .ee_ce_n_o(ce_n), .ee_oe_n_o(oe_n), .ee_we_n_o(we_n),
    .ee_data_o(ee_data), .ee_data_oe_o(data_oe), .ee_data_i(ee_bus));
  pewp_eeprom_model #(.AW(AW), .PROG_T(400ns)) dev (
    .addr_i(ee_addr), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
    .data_i(ee_bus), .vcc_ok_i(supply_ok), .data_o(dev_q), .prog_o(prog));
  // Count write strobes that reach the device, so gating is seen apart from the model
  always @(negedge we_n) n_we++;
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (e !== g) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8
  task automatic chk1(input string nm, input logic e, input logic g);
    chk8(nm, {7'h00, e}, {7'h00, g});
  endtask : chk1
  // One request, then wait for completion under a bound
  task automatic op(input logic w, input logic [AW-1:0] a, input logic [7:0] d);
    @(negedge core_clk);
    req = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    @(negedge core_clk);
    req = 1'b0;
    chk1("busy_taken", 1'b1, busy);
    wait_n = 0;
    while (done !== 1'b1 && wait_n < 2000) begin
      @(posedge core_clk);
      #1;
      wait_n++;
    end
    chk1("done", 1'b1, done);
    chk1("busy_end", 1'b0, busy);
  endtask : op
  // Write then read back; completion must wait for programming
  task automatic t_write_read(input logic [AW-1:0] a, input logic [7:0] d);
    int we0;
    we0 = n_we;
    op(1'b1, a, d);
    chk1("we_strobe", 1'b1, n_we == we0 + 1);
    chk1("timeout", 1'b0, timeout);
    chk1("prog_at_done", 1'b0, prog);
    chk1("poll_wait", 1'b1, wait_n >= 50);
    op(1'b0, a, 8'h00);
    chk8("rdata", d, rdata);
  endtask : t_write_read
  // Low supply: strobe gated off, polling times out, old data kept
  task automatic t_supply_low();
    int we0;
    @(negedge core_clk);
    supply_ok = 1'b0;
    repeat (4) @(negedge core_clk);
    we0 = n_we;
    op(1'b1, 12'h000, 8'h11);
    chk1("we_gated", 1'b1, n_we == we0);
    chk1("timeout_low", 1'b1, timeout);
    chk1("prog_low", 1'b0, prog);
    @(negedge core_clk);
    supply_ok = 1'b1;
    repeat (4) @(negedge core_clk);
    op(1'b0, 12'h000, 8'h00);
    chk1("timeout_clr", 1'b0, timeout);
    chk8("rdata_kept", 8'ha5, rdata);
  endtask : t_supply_low
  task automatic test_done();
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  // Watchdog well beyond the expected run length
  initial begin
    #200us;
    n_fail++;
    test_done();
  end
  initial begin
    n_fail = 0;
    n_compared = 0;
    n_we = 0;
    rst_n = 1'b0;
    req = 1'b0;
    req_write = 1'b0;
    req_addr = '0;
    req_wdata = 8'h00;
    supply_ok = 1'b1;
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    t_write_read(12'h000, 8'ha5);
    t_write_read(12'hfff, 8'h3c);
    t_write_read(12'h7ff, 8'hc3);
    t_supply_low();
    test_done();
  end
endmodule : parallel_eeprom_write_and_polling_tb
